//--- core/lfm_pkg.sv
// constants, command codes and register map of the lf modulator stage
// assumes: one 100 MHz clock, software access over axi4-lite

package lfm_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int          AXI_AW       = 8;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_CMD      = 8'h04;
	localparam logic [7:0]  REG_STAT     = 8'h08;
	localparam int          CTRL_RUN     = 0;
	localparam int          CTRL_HALT    = 1;
	localparam int          STAT_OVF     = 8;
	localparam int          STAT_BUSY    = 9;
	localparam int          STAT_ACT     = 10;
	localparam int          STAT_HS      = 11;
	localparam int          STAT_DRV     = 12;
	localparam int          STAT_DIAG    = 15;
	localparam int          STAT_CUR     = 16;
	localparam int          STAT_HALT    = 21;
	localparam logic        RUN_RST      = 1'b0;
	localparam logic [2:0]  DRV_RST      = 3'h0;
	localparam logic [4:0]  CUR_RST      = 5'h00;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------
	// command codes (upper bits of a buffered byte)
	// ------------------------------------------------------------
	localparam logic [2:0]  OP_DRV       = 3'h1;
	localparam logic [2:0]  OP_CUR       = 3'h5;
	localparam logic [2:0]  OP_CAR       = 3'h4;
	localparam logic [3:0]  OP_DATA      = 4'h0;
	localparam int          BR_BIT       = 4;
	localparam int          DM_BIT       = 3;

	// ------------------------------------------------------------
	// lf period length in clocks, timing counts in lf periods
	// ------------------------------------------------------------
	localparam int          LF_DIV       = 64;
	localparam logic [9:0]  DRV_TOTAL    = 10'h040;
	localparam logic [9:0]  DRV_STOP     = 10'h020;
	localparam logic [9:0]  CUR_PERIODS  = 10'h004;
	localparam logic [9:0]  BIT_STD      = 10'h020;
	localparam logic [9:0]  BIT_HS       = 10'h016;
	localparam logic [9:0]  BURST_STD    = 10'h010;
	localparam logic [9:0]  BURST_HS     = 10'h00b;
	localparam logic [2:0]  MEAS_DELAY   = 3'h4;

	typedef enum logic [2:0] {
		LFM_CMD_DRV,
		LFM_CMD_CUR,
		LFM_CMD_CAR,
		LFM_CMD_DATA,
		LFM_CMD_BAD
	} lfm_cmd_e;

endpackage

//--- core/lfm_period_timer.sv
// lf period timer: divides the system clock into lf period ticks
// assumes: synchronous active high reset, free running clock
`timescale 1ns/1ps
`default_nettype none

module lfm_period_timer #(
	parameter int DIV = lfm_pkg::LF_DIV
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// period outputs
	output logic      lf_tick,
	output logic      lf_phase
);

	localparam int CW = $clog2(DIV);

	logic [CW-1:0] div_cnt_ff;
	logic          tick_ff;
	logic          phase_ff;

	// ------------------------------------------------------------
	// divider
	// ------------------------------------------------------------
	// count clocks, one tick per lf period
	always_ff @(posedge clock) begin
		if (rst) begin
			div_cnt_ff <= '0;
			tick_ff    <= 1'b0;
			phase_ff   <= 1'b0;
		end else begin
			tick_ff <= (div_cnt_ff == CW'(DIV - 1));
			if (div_cnt_ff == CW'(DIV - 1)) begin
				div_cnt_ff <= '0;
			end else begin
				div_cnt_ff <= div_cnt_ff + 1'b1;
			end
			phase_ff <= (div_cnt_ff >= CW'(DIV / 2)); // carrier phase
		end
	end

	assign lf_tick  = tick_ff;
	assign lf_phase = phase_ff;

endmodule

`default_nettype wire

//--- core/lfm_modulator.sv
// lf modulator stage: command buffer, sequencer, ook drive, traces
// assumes: axi4-lite master on the same clock, coil driver stages
// outside that follow coil_drive_on and coil_select
`timescale 1ns/1ps
`default_nettype none

module lfm_modulator #(
	parameter int DEPTH = 16,
	parameter int DIV   = lfm_pkg::LF_DIV
) (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// axi4-lite write address
	input  wire logic [lfm_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	// axi4-lite read address
	input  wire logic [lfm_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// coil driver control
	output logic                            coil_drive_on,
	output logic [2:0]                      coil_select,
	output logic [4:0]                      coil_current,
	output logic                            diag_select,
	output logic                            high_speed,
	output logic                            lf_carrier_phase,
	output logic                            measure_enable,
	// trace outputs
	output logic                            transmit_active_trace,
	output logic                            lf_bit_change_trace
);

	localparam int PW = $clog2(DEPTH);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DRV,
		ST_CUR,
		ST_DATA,
		ST_CAR
	} lfm_state_e;

	// classify a buffered byte
	function automatic lfm_pkg::lfm_cmd_e lfm_decode(
		input logic [7:0] b
	);
		if (b[7:4] == lfm_pkg::OP_DATA) begin
			return lfm_pkg::LFM_CMD_DATA;
		end else if (b[7:5] == lfm_pkg::OP_DRV) begin
			return lfm_pkg::LFM_CMD_DRV;
		end else if (b[7:5] == lfm_pkg::OP_CUR) begin
			return lfm_pkg::LFM_CMD_CUR;
		end else if (b[7:5] == lfm_pkg::OP_CAR) begin
			return lfm_pkg::LFM_CMD_CAR;
		end
		return lfm_pkg::LFM_CMD_BAD;
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0]       mem [DEPTH];
	logic [PW-1:0]    rd_ptr_ff;
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW:0]      fill_ff;
	logic             run_ff;
	logic             halt_ff;
	logic             ovf_ff;
	logic             aw_hold_ff;
	logic             w_hold_ff;
	logic [7:0]       aw_addr_ff;
	logic [31:0]      w_data_ff;
	logic [3:0]       w_strb_ff;
	logic             bvalid_ff;
	logic [1:0]       bresp_ff;
	logic             rvalid_ff;
	logic [31:0]      rdata_ff;
	logic [1:0]       rresp_ff;
	lfm_state_e       state_ff;
	logic [9:0]       per_cnt_ff;
	logic [5:0]       bits_left_ff;
	logic [7:0]       shift_ff;
	logic [2:0]       bit_pos_ff;
	logic             field_ff;
	logic [2:0]       drv_ff;
	logic             diag_ff;
	logic             speed_ff;
	logic [2:0]       pend_drv_ff;
	logic             pend_diag_ff;
	logic             pend_speed_ff;
	logic [4:0]       cur_ff;
	logic             act_ff;
	logic             lf_bit_change_trace_ff;
	logic [2:0]       on_cnt_ff;
	logic             meas_ff;
	logic             lf_tick;
	logic             wr_do;
	logic             push;
	logic             flush;
	logic [1:0]       pop_n;
	logic [7:0]       head;
	logic [7:0]       head1;
	lfm_pkg::lfm_cmd_e head_kind;
	logic             can_start;
	logic             seg_end;
	logic             cmd_end;
	logic             start_now;
	logic [9:0]       bit_len;
	logic [9:0]       burst_min;
	logic [9:0]       car_len;
	logic [4:0]       nibbles;

	// ------------------------------------------------------------
	// lf period timing
	// ------------------------------------------------------------
	lfm_period_timer #(
		.DIV (DIV)
	) u_timer (
		.clock    (clock),
		.rst      (rst),
		.lf_tick  (lf_tick),
		.lf_phase (lf_carrier_phase)
	);

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_hold_ff;
	assign s_axi_wready  = !w_hold_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign wr_do         = aw_hold_ff && w_hold_ff && !bvalid_ff;

	// catch address and data in either order, answer once both held
	always_ff @(posedge clock) begin
		if (rst) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= lfm_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_hold_ff) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_do) begin
				aw_hold_ff <= 1'b0;
			end
			if (s_axi_wvalid && !w_hold_ff) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_do) begin
				w_hold_ff <= 1'b0;
			end
			if (wr_do) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= (aw_addr_ff == lfm_pkg::REG_CTRL ||
					aw_addr_ff == lfm_pkg::REG_CMD ||
					aw_addr_ff == lfm_pkg::REG_STAT) ?
					lfm_pkg::RESP_OKAY : lfm_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// control bits: run level, halt request, overflow flag
	always_ff @(posedge clock) begin
		if (rst) begin
			run_ff  <= lfm_pkg::RUN_RST;
			halt_ff <= 1'b0;
			ovf_ff  <= 1'b0;
		end else begin
			if (wr_do && aw_addr_ff == lfm_pkg::REG_CTRL && w_strb_ff[0]) begin
				run_ff <= w_data_ff[lfm_pkg::CTRL_RUN];
			end
			// a new request in the flush cycle stays pending
			if (wr_do && aw_addr_ff == lfm_pkg::REG_CTRL && w_strb_ff[0] &&
				w_data_ff[lfm_pkg::CTRL_HALT]) begin
				halt_ff <= 1'b1;
			end else if (lf_tick) begin
				halt_ff <= 1'b0;
			end
			// overflow set wins over write-one clear
			if (wr_do && aw_addr_ff == lfm_pkg::REG_CMD && w_strb_ff[0] &&
				fill_ff == (PW+1)'(DEPTH) && !flush) begin
				ovf_ff <= 1'b1;
			end else if (wr_do && aw_addr_ff == lfm_pkg::REG_STAT &&
				w_strb_ff[1] && w_data_ff[lfm_pkg::STAT_OVF]) begin
				ovf_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// register read mux, answer one cycle after the address
	always_ff @(posedge clock) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= lfm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= lfm_pkg::RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
			case ({s_axi_araddr[7:2], 2'b00})
				lfm_pkg::REG_CTRL: begin
					rdata_ff[lfm_pkg::CTRL_RUN] <= run_ff;
				end
				lfm_pkg::REG_CMD: begin
					rdata_ff <= 32'h0000_0000;
				end
				lfm_pkg::REG_STAT: begin
					rdata_ff[PW:0]                 <= fill_ff;
					rdata_ff[lfm_pkg::STAT_OVF]    <= ovf_ff;
					rdata_ff[lfm_pkg::STAT_BUSY]   <= (state_ff != ST_IDLE);
					rdata_ff[lfm_pkg::STAT_ACT]    <= act_ff;
					rdata_ff[lfm_pkg::STAT_HS]     <= speed_ff;
					rdata_ff[lfm_pkg::STAT_DRV+:3] <= drv_ff;
					rdata_ff[lfm_pkg::STAT_DIAG]   <= diag_ff;
					rdata_ff[lfm_pkg::STAT_CUR+:5] <= cur_ff;
					rdata_ff[lfm_pkg::STAT_HALT]   <= halt_ff;
				end
				default: begin
					rresp_ff <= lfm_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// command buffer
	// ------------------------------------------------------------
	assign push  = wr_do && aw_addr_ff == lfm_pkg::REG_CMD && w_strb_ff[0] &&
		(fill_ff != (PW+1)'(DEPTH) || flush);
	assign flush = halt_ff && lf_tick;
	assign head  = mem[rd_ptr_ff];
	assign head1 = mem[rd_ptr_ff + 1'b1];

	// fifo keeps arrival order, halt empties it at a period end
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_ptr_ff <= '0;
			wr_ptr_ff <= '0;
			fill_ff   <= '0;
		end else if (flush) begin
			rd_ptr_ff <= '0;
			wr_ptr_ff <= PW'(push);
			fill_ff   <= (PW+1)'(push);
		end else begin
			rd_ptr_ff <= rd_ptr_ff + PW'(pop_n);
			wr_ptr_ff <= wr_ptr_ff + PW'(push);
			fill_ff   <= fill_ff + (PW+1)'(push) - (PW+1)'(pop_n);
		end
	end

	// buffer storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem[flush ? '0 : wr_ptr_ff] <= w_data_ff[7:0];
		end
	end

	// ------------------------------------------------------------
	// look-ahead decode of the next command
	// ------------------------------------------------------------
	assign head_kind = lfm_decode(head);
	assign bit_len   = speed_ff ? lfm_pkg::BIT_HS : lfm_pkg::BIT_STD;
	assign burst_min = speed_ff ? lfm_pkg::BURST_HS : lfm_pkg::BURST_STD;
	assign car_len   = 10'(head[4:0] * bit_len);
	assign nibbles   = (head[3:0] == 4'h0) ? 5'h10 : {1'b0, head[3:0]};
	assign can_start = fill_ff != '0 && !halt_ff &&
		(head_kind != lfm_pkg::LFM_CMD_DATA || fill_ff > (PW+1)'(1));
	assign seg_end   = lf_tick && per_cnt_ff == 10'h001;
	assign cmd_end   = seg_end && state_ff != ST_IDLE &&
		(state_ff != ST_DATA || bits_left_ff == 6'h01);
	assign start_now = lf_tick && can_start &&
		((state_ff == ST_IDLE && run_ff) || cmd_end);

	// number of bytes taken from the buffer this cycle
	always_comb begin
		pop_n = 2'h0;
		if (start_now) begin
			pop_n = (head_kind == lfm_pkg::LFM_CMD_DATA) ? 2'h2 : 2'h1;
		end else if (state_ff == ST_DATA && seg_end && !cmd_end &&
			bit_pos_ff == 3'h7 && fill_ff != '0 && !halt_ff) begin
			pop_n = 2'h1;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// runs one command at a time, next one starts on the last tick
	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff      <= ST_IDLE;
			per_cnt_ff    <= 10'h000;
			bits_left_ff  <= 6'h00;
			shift_ff      <= 8'h00;
			bit_pos_ff    <= 3'h0;
			field_ff      <= 1'b0;
			drv_ff        <= lfm_pkg::DRV_RST;
			diag_ff       <= 1'b0;
			speed_ff      <= 1'b0;
			pend_drv_ff   <= lfm_pkg::DRV_RST;
			pend_diag_ff  <= 1'b0;
			pend_speed_ff <= 1'b0;
			cur_ff        <= lfm_pkg::CUR_RST;
			act_ff        <= 1'b0;
			lf_bit_change_trace_ff       <= 1'b0;
		end else if (flush) begin
			state_ff <= ST_IDLE;
			field_ff <= 1'b0;
			act_ff   <= 1'b0;
		end else if (start_now) begin
			case (head_kind)
				lfm_pkg::LFM_CMD_DRV: begin
					state_ff      <= ST_DRV;
					per_cnt_ff    <= lfm_pkg::DRV_TOTAL;
					pend_drv_ff   <= head[2:0];
					pend_diag_ff  <= head[lfm_pkg::DM_BIT];
					pend_speed_ff <= head[lfm_pkg::BR_BIT];
					field_ff      <= 1'b0;
					act_ff        <= 1'b0;
				end
				lfm_pkg::LFM_CMD_CUR: begin
					state_ff   <= ST_CUR;
					per_cnt_ff <= lfm_pkg::CUR_PERIODS;
					cur_ff     <= head[4:0];
					field_ff   <= 1'b0;
					act_ff     <= 1'b0;
				end
				lfm_pkg::LFM_CMD_CAR: begin
					state_ff   <= ST_CAR;
					per_cnt_ff <= (car_len < burst_min) ?
						burst_min : car_len;
					field_ff   <= 1'b1;
					act_ff     <= 1'b1;
				end
				lfm_pkg::LFM_CMD_DATA: begin
					state_ff     <= ST_DATA;
					per_cnt_ff   <= bit_len;
					bits_left_ff <= {nibbles, 1'b0};
					shift_ff     <= head1;
					bit_pos_ff   <= 3'h0;
					field_ff     <= head1[0];
					act_ff       <= 1'b1;
					lf_bit_change_trace_ff      <= !lf_bit_change_trace_ff;
				end
				default: begin
					state_ff <= ST_IDLE;
					field_ff <= 1'b0;
					act_ff   <= 1'b0;
				end
			endcase
		end else if (cmd_end) begin
			state_ff <= ST_IDLE;
			field_ff <= 1'b0;
			act_ff   <= 1'b0;
		end else if (state_ff == ST_DATA && seg_end) begin
			per_cnt_ff   <= bit_len;
			bits_left_ff <= bits_left_ff - 6'h01;
			lf_bit_change_trace_ff      <= lf_bit_change_trace_ff ^ (bit_pos_ff != 3'h7 || pop_n == 2'h1);
			if (bit_pos_ff != 3'h7) begin
				shift_ff   <= {1'b0, shift_ff[7:1]};
				field_ff   <= shift_ff[1];
				bit_pos_ff <= bit_pos_ff + 3'h1;
			end else if (pop_n == 2'h1) begin
				shift_ff   <= head;
				field_ff   <= head[0];
				bit_pos_ff <= 3'h0;
			end else begin
				state_ff <= ST_IDLE; // data ran out
				field_ff <= 1'b0;
				act_ff   <= 1'b0;
			end
		end else if (state_ff != ST_IDLE && lf_tick) begin
			per_cnt_ff <= per_cnt_ff - 10'h001;
			// coil swaps after the decay half of the select time
			if (state_ff == ST_DRV &&
				per_cnt_ff == lfm_pkg::DRV_TOTAL - lfm_pkg::DRV_STOP + 10'h001) begin
				drv_ff   <= pend_drv_ff;
				diag_ff  <= pend_diag_ff;
				speed_ff <= pend_speed_ff;
			end
		end
	end

	// ------------------------------------------------------------
	// current measurement window
	// ------------------------------------------------------------
	// hold off measurement for four periods after the field comes on
	always_ff @(posedge clock) begin
		if (rst) begin
			on_cnt_ff <= 3'h0;
			meas_ff   <= 1'b0;
		end else begin
			if (!field_ff) begin
				on_cnt_ff <= 3'h0;
			end else if (lf_tick && on_cnt_ff != lfm_pkg::MEAS_DELAY) begin
				on_cnt_ff <= on_cnt_ff + 3'h1;
			end
			meas_ff <= field_ff && on_cnt_ff == lfm_pkg::MEAS_DELAY;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign coil_drive_on         = field_ff;
	assign coil_select           = drv_ff;
	assign coil_current          = cur_ff;
	assign diag_select           = diag_ff;
	assign high_speed            = speed_ff;
	assign measure_enable        = meas_ff;
	assign transmit_active_trace = act_ff;
	assign lf_bit_change_trace   = lf_bit_change_trace_ff;

endmodule

`default_nettype wire

//--- test/lfm_coil_model.sv
// coil partner model: integrates the time the coil field is driven
// assumes: the modulator drive level and a bench clear on one clock
`timescale 1ns/1ps
`default_nettype none

module lfm_coil_model (
	// clock and clear
	input  wire logic        clock,
	input  wire logic        clr,
	// drive level from the modulator
	input  wire logic        coil_drive_on,
	// accumulated field on-time in clocks
	output logic      [31:0] on_time
);
	// the coil carries field only while driven on
	always_ff @(posedge clock) begin
		if (clr)
			on_time <= 32'h0;
		else if (coil_drive_on)
			on_time <= on_time + 32'h1;
	end
endmodule

`default_nettype wire

//--- test/lfm_checker.sv
// checker of the modulator drive and trace outputs
// assumes: bound to the modulator top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none

module lfm_checker #(
	parameter int DIV = lfm_pkg::LF_DIV
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// coil drive and traces
	input  wire logic       coil_drive_on,
	input  wire logic [2:0] coil_select,
	input  wire logic [4:0] coil_current,
	input  wire logic       measure_enable,
	input  wire logic       transmit_active_trace,
	input  wire logic       lf_bit_change_trace
);
	localparam int MEAS  = int'(lfm_pkg::MEAS_DELAY) * DIV;
	localparam int BURST = int'(lfm_pkg::BURST_HS) * DIV;
	localparam int BITL  = int'(lfm_pkg::BIT_HS) * DIV;
	localparam int STOP  = int'(lfm_pkg::DRV_STOP) * DIV - 2;
	logic [31:0] on_cnt_ff;
	logic [31:0] off_cnt_ff;
	logic [31:0] gap_cnt_ff;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// ----------------------------------------------------------
	// run lengths of field on, field off and bit trace level
	// ----------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			on_cnt_ff  <= 32'h0;
			off_cnt_ff <= 32'h0;
			gap_cnt_ff <= 32'h4000_0000;
		end else begin
			on_cnt_ff  <= coil_drive_on ? on_cnt_ff + 32'h1 : 32'h0;
			off_cnt_ff <= coil_drive_on ? 32'h0 : off_cnt_ff + 32'h1;
			gap_cnt_ff <= $changed(lf_bit_change_trace) ? 32'h1
				: gap_cnt_ff + 32'h1;
		end
	end

	sequence s_off4;
		!coil_drive_on [*4];
	endsequence
	property p_field_tx;
		coil_drive_on |-> transmit_active_trace;
	endproperty
	property p_act_off;
		$fell(transmit_active_trace) |-> !coil_drive_on;
	endproperty
	property p_meas;
		measure_enable |-> on_cnt_ff >= MEAS;
	endproperty
	property p_burst;
		$fell(coil_drive_on) |-> on_cnt_ff >= BURST;
	endproperty
	property p_bit_tx;
		$changed(lf_bit_change_trace) |-> transmit_active_trace;
	endproperty
	property p_bit_gap;
		$changed(lf_bit_change_trace) |-> gap_cnt_ff >= BITL;
	endproperty
	property p_sel;
		$changed(coil_select) |-> !coil_drive_on && off_cnt_ff >= STOP;
	endproperty
	property p_cur;
		$changed(coil_current) |-> s_off4;
	endproperty

	a_field_tx: assert property (p_field_tx)
		else $error("field on outside a transmission");
	a_act_off: assert property (p_act_off)
		else $error("field left on at end of transmission");
	a_meas: assert property (p_meas)
		else $error("measurement too early after field rise");
	a_burst: assert property (p_burst)
		else $error("field burst shorter than minimum");
	a_bit_tx: assert property (p_bit_tx)
		else $error("bit trace moved outside a transmission");
	a_bit_gap: assert property (p_bit_gap)
		else $error("bit changes closer than one bit time");
	a_sel: assert property (p_sel)
		else $error("driver switched before decay time");
	a_cur: assert property (p_cur)
		else $error("current change without a gap");
endmodule

`default_nettype wire

//--- test/tb.sv
// self-checking bench of the modulator stage over axi4-lite
// assumes: lfm_pkg compiled first, checker bound below
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int DIV = 4;
	logic        clock, rst, clr;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, on_time;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, coil_drive_on, high_speed;
	logic        transmit_active_trace, lf_bit_change_trace, diag_select;
	logic        lf_carrier_phase;
	logic [2:0]  coil_select;
	logic [4:0]  coil_current;
	int          err_count, checks_done;

	lfm_modulator #(.DIV(DIV)) dut (.clock, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.coil_drive_on, .coil_select, .coil_current, .diag_select,
		.high_speed, .lf_carrier_phase, .measure_enable(),
		.transmit_active_trace, .lf_bit_change_trace);
	lfm_coil_model u_coil (.clock, .clr, .coil_drive_on, .on_time);

	// clock of 10 ns period
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo;
		$display("ERROR %0t: wait bound used up", $time);
		err_count++;
		end_of_test();
	endtask
	// one axi4-lite write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 64) tmo();
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, lfm_pkg::RESP_OKAY);
	endtask
	// one axi4-lite read with expected response and data
	task automatic rd(input logic [7:0] a, input logic [1:0] er,
		input logic [31:0] ed);
		int n;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 64) tmo();
		s_axi_rready <= 1'b0;
		chk(s_axi_rresp, er);
		chk(s_axi_rdata, ed);
	endtask
	task automatic wait_act;
		int n;
		for (n = 0; n < 4000 && transmit_active_trace !== 1'b1; n++)
			@(posedge clock);
		if (n == 4000) tmo();
	endtask
	// clocks the carrier holds the field, never below the minimum burst
	function automatic int car_clk(input logic br, input logic [4:0] t);
		int bit_n, min_n;
		bit_n = br ? int'(lfm_pkg::BIT_HS) : int'(lfm_pkg::BIT_STD);
		min_n = br ? int'(lfm_pkg::BURST_HS) : int'(lfm_pkg::BURST_STD);
		return DIV * ((t * bit_n < min_n) ? min_n : t * bit_n);
	endfunction
	// driver, current, four data bits, carrier; then trace the telegram
	task automatic run_seq(input logic br, input logic [7:0] r,
		input logic [4:0] t);
		logic [2:0] d;
		logic [4:0] c;
		logic       tr0, dm;
		int         bl, cl, ph, k, j;
		d = 3'(1 + $urandom % 5);
		c = 5'(1 + $urandom % 19);
		dm = 1'($urandom % 2);
		bl = DIV * (br ? int'(lfm_pkg::BIT_HS) : int'(lfm_pkg::BIT_STD));
		cl = car_clk(br, t);
		ph = 0;
		wr(lfm_pkg::REG_CMD, {24'h0, 3'b001, br, dm, d});
		wr(lfm_pkg::REG_CMD, {24'h0, 3'b101, c});
		wr(lfm_pkg::REG_CMD, 32'h02);
		wr(lfm_pkg::REG_CMD, {24'h0, r});
		wr(lfm_pkg::REG_CMD, {24'h0, 3'b100, t});
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		wait_act();
		chk(coil_select, d);
		chk(coil_current, c);
		chk(high_speed, br);
		chk(diag_select, dm);
		tr0 = lf_bit_change_trace;
		for (k = 0; k < 4000 && transmit_active_trace === 1'b1; k++) begin
			j = k / bl;
			ph += lf_carrier_phase;
			if (k % bl == bl / 2) begin
				chk(coil_drive_on, j < 4 ? r[j] : 1'b1);
				chk(lf_bit_change_trace, tr0 ^ (j < 4 ? j[0] : 1'b1));
			end
			@(posedge clock);
		end
		chk(k, 4 * bl + cl);
		chk(coil_drive_on, 1'b0);
		chk(on_time, (r[0] + r[1] + r[2] + r[3]) * bl + cl);
		chk(ph, (4 * bl + cl) / 2);
	endtask

	// watchdog against a hang
	initial begin
		repeat (100000) @(posedge clock);
		tmo();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		clr = 1'b0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		err_count = 0;
		checks_done = 0;
		void'($urandom(32'h5f5e3b9b));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(lfm_pkg::REG_STAT, lfm_pkg::RESP_OKAY, 32'h0);
		for (int i = 0; i < 17; i++)
			wr(lfm_pkg::REG_CMD, 32'h21);
		rd(lfm_pkg::REG_STAT, lfm_pkg::RESP_OKAY, 32'h110);
		wr(lfm_pkg::REG_CTRL, 32'h2);
		repeat (2 * DIV) @(posedge clock);
		rd(lfm_pkg::REG_STAT, lfm_pkg::RESP_OKAY, 32'h100);
		wr(lfm_pkg::REG_STAT, 32'h100);
		rd(lfm_pkg::REG_STAT, lfm_pkg::RESP_OKAY, 32'h0);
		rd(8'h0c, lfm_pkg::RESP_SLVERR, 32'h0);
		wr(lfm_pkg::REG_CTRL, 32'h1);
		run_seq(1'b0, 8'h05, 5'h01);
		run_seq(1'b1, 8'($urandom), 5'(1 + $urandom % 3));
		run_seq(1'b0, 8'h0a, 5'h00);
		end_of_test();
	end
endmodule

bind lfm_modulator lfm_checker #(.DIV(DIV)) u_chk (.clock(clock),
	.rst(rst), .coil_drive_on(coil_drive_on), .coil_select(coil_select),
	.coil_current(coil_current), .measure_enable(measure_enable),
	.transmit_active_trace(transmit_active_trace),
	.lf_bit_change_trace(lf_bit_change_trace));

`default_nettype wire
